// >>> verilog/prcfl_top.sv
`timescale 1ns/1ps
module prcfl_top #(
    parameter int SHORT_CYCLES = prcfl_pkg::SHORT_CYC,
    parameter int GPIO_W = 8
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic power_on_input,
    input wire logic emergency_shutdown_n,
    input wire prcfl_pkg::prcfl_sense_s sense,
    input wire logic [prcfl_pkg::NUM_UNIT-1:0] in_regulation,
    output logic rail_1p2_en,
    output logic rail_1p8_en,
    output logic rail_3p3_en,
    output logic rail_5p0_en,
    output logic adjustable_buck_en,
    output logic boost_converter_en,
    output logic current_limited_switch_en,
    output logic current_sense_amp_en,
    output logic open_drain_comparator_en,
    output logic sense_gain_40,
    output logic fault_output_n,
    input wire logic [GPIO_W-1:0] gpio_in,
    output logic [GPIO_W-1:0] gpio_out,
    output logic [GPIO_W-1:0] gpio_oe,
    output logic [GPIO_W-1:0] gpio_pullup_en
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int SW = 2 + $bits(prcfl_pkg::prcfl_sense_s) + prcfl_pkg::NUM_UNIT + GPIO_W;
    logic [SW-1:0] raw_in;
    logic [SW-1:0] syn_in;
    logic pwr_s;
    logic emergency_shutdown_n_n_s;
    prcfl_pkg::prcfl_sense_s sen_s;
    logic [prcfl_pkg::NUM_UNIT-1:0] reg_s;
    logic [GPIO_W-1:0] gin_s;

    assign raw_in = {power_on_input, emergency_shutdown_n, sense, in_regulation, gpio_in};
    assign {pwr_s, emergency_shutdown_n_n_s, sen_s, reg_s, gin_s} = syn_in;

    prcfl_sync #(.W(SW)) u_sync (
        .mclk(mclk),
        .nrst(nrst),
        .d(raw_in),
        .q(syn_in)
    );

    // ****************************************
    // APB slave
    // ****************************************
    logic [7:0] enable_q;
    logic [7:0] mode_q;
    logic [7:0] shut_mask_q;
    logic [15:0] gpio_mode_q;
    logic [GPIO_W-1:0] gpio_dout_q;
    logic [GPIO_W-1:0] pwm_en_q;
    logic [GPIO_W-1:0] pwm_bank_q;
    logic [7:0] duty0_q;
    logic [7:0] duty1_q;
    logic [prcfl_pkg::NUM_SF-1:0] sys_flags;
    logic [prcfl_pkg::NUM_UNIT-1:0] ol_flags;
    logic [prcfl_pkg::NUM_UNIT-1:0] vok_flags;
    logic wr_acc;
    logic rd_acc;
    logic rd_sys;
    logic rd_ol;
    logic rd_vok;

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a <= prcfl_pkg::ADDR_PWM_DUTY1) && (a[1:0] == 2'h0);
    endfunction

    // Zero-wait access phase: every transfer completes in its first access cycle
    assign wr_acc = psel && penable && pwrite && addr_known(paddr);
    assign rd_acc = psel && penable && !pwrite && addr_known(paddr);
    assign rd_sys = rd_acc && (paddr == prcfl_pkg::ADDR_SYS_FAULT);
    assign rd_ol = rd_acc && (paddr == prcfl_pkg::ADDR_OVERLOAD);
    assign rd_vok = rd_acc && (paddr == prcfl_pkg::ADDR_VOK_FAULT);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_known(paddr);
        end
    end

    // Low byte only; upper bytes of pwdata are ignored
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            enable_q <= prcfl_pkg::RST_ENABLE;
            mode_q <= prcfl_pkg::RST_MODE;
            shut_mask_q <= prcfl_pkg::RST_SHUTDOWN;
            gpio_mode_q <= 16'h0000;
            gpio_dout_q <= '0;
            pwm_en_q <= '0;
            pwm_bank_q <= '0;
            duty0_q <= 8'h00;
            duty1_q <= 8'h00;
        end else if (wr_acc && pready) begin
            case (paddr)
                prcfl_pkg::ADDR_ENABLE: enable_q <= {2'h0, pwdata[5:0]};
                prcfl_pkg::ADDR_MODE: mode_q <= {6'h00, pwdata[1:0]};
                prcfl_pkg::ADDR_SHUTDOWN: shut_mask_q <= {2'h0, pwdata[5:0]};
                prcfl_pkg::ADDR_GPIO_MODE_LO: gpio_mode_q[7:0] <= pwdata[7:0];
                prcfl_pkg::ADDR_GPIO_MODE_HI: gpio_mode_q[15:8] <= pwdata[7:0];
                prcfl_pkg::ADDR_GPIO_OUT: gpio_dout_q <= pwdata[GPIO_W-1:0];
                prcfl_pkg::ADDR_PWM_EN: pwm_en_q <= pwdata[GPIO_W-1:0];
                prcfl_pkg::ADDR_PWM_BANK: pwm_bank_q <= pwdata[GPIO_W-1:0];
                prcfl_pkg::ADDR_PWM_DUTY0: duty0_q <= pwdata[7:0];
                prcfl_pkg::ADDR_PWM_DUTY1: duty1_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata <= prcfl_pkg::RST_ZERO;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                prcfl_pkg::ADDR_ENABLE: prdata <= {24'h00_0000, enable_q};
                prcfl_pkg::ADDR_MODE: prdata <= {24'h00_0000, mode_q};
                prcfl_pkg::ADDR_SHUTDOWN: prdata <= {24'h00_0000, shut_mask_q};
                prcfl_pkg::ADDR_SYS_FAULT: prdata <= {26'h000_0000, sys_flags};
                prcfl_pkg::ADDR_OVERLOAD: prdata <= {25'h000_0000, ol_flags};
                prcfl_pkg::ADDR_VOK_FAULT: prdata <= {25'h000_0000, vok_flags};
                prcfl_pkg::ADDR_GPIO_MODE_LO: prdata <= {24'h00_0000, gpio_mode_q[7:0]};
                prcfl_pkg::ADDR_GPIO_MODE_HI: prdata <= {24'h00_0000, gpio_mode_q[15:8]};
                prcfl_pkg::ADDR_GPIO_OUT: prdata <= {24'h00_0000, gpio_dout_q};
                prcfl_pkg::ADDR_GPIO_IN: prdata <= {24'h00_0000, gin_s};
                prcfl_pkg::ADDR_PWM_EN: prdata <= {24'h00_0000, pwm_en_q};
                prcfl_pkg::ADDR_PWM_BANK: prdata <= {24'h00_0000, pwm_bank_q};
                prcfl_pkg::ADDR_PWM_DUTY0: prdata <= {24'h00_0000, duty0_q};
                prcfl_pkg::ADDR_PWM_DUTY1: prdata <= {24'h00_0000, duty1_q};
                default: prdata <= prcfl_pkg::RST_ZERO;
            endcase
        end
    end

    // ****************************************
    // Fault status
    // ****************************************
    logic [prcfl_pkg::NUM_SF-1:0] sys_cond;
    logic [prcfl_pkg::NUM_UNIT-1:0] vok_cond;
    logic input_overcurrent_flag_cond;

    assign input_overcurrent_flag_cond = mode_q[prcfl_pkg::MODE_OCDET] && sen_s.in_overcurrent;
    assign vok_cond = sen_s.soft_start_fail | sen_s.vok_low;
    assign sys_cond = {sen_s.in_overvolt, input_overcurrent_flag_cond, sen_s.over_temp,
                       |sen_s.overload, |vok_cond, sen_s.bst_fault};

    prcfl_sticky #(.W(prcfl_pkg::NUM_SF)) u_sys (
        .mclk(mclk),
        .nrst(nrst),
        .cond(sys_cond),
        .rd(rd_sys && pready),
        .flags(sys_flags)
    );

    prcfl_sticky #(.W(prcfl_pkg::NUM_UNIT)) u_ol (
        .mclk(mclk),
        .nrst(nrst),
        .cond(sen_s.overload),
        .rd(rd_ol && pready),
        .flags(ol_flags)
    );

    prcfl_sticky #(.W(prcfl_pkg::NUM_UNIT)) u_vok (
        .mclk(mclk),
        .nrst(nrst),
        .cond(vok_cond),
        .rd(rd_vok && pready),
        .flags(vok_flags)
    );

    // Registered output: any raw fault except cls_short, with input overcurrent only when MODE_OCDET is set, pulls the pin on the next edge
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fault_output_n <= 1'b1;
        end else begin
            fault_output_n <= !(|sys_cond);
        end
    end

    // ****************************************
    // Rail sequencing and block enables
    // ****************************************
    logic r5_reached_q;
    logic [31:0] short_cnt_q;
    logic cls_latched_q;
    logic [prcfl_pkg::NUM_BLK-1:0] keep;

    // Mask bit 1 keeps block alive while shutdown is asserted
    assign keep = emergency_shutdown_n_n_s ? {prcfl_pkg::NUM_BLK{1'b1}} : shut_mask_q[prcfl_pkg::NUM_BLK-1:0];

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            r5_reached_q <= 1'b0;
        end else if (!pwr_s) begin
            r5_reached_q <= 1'b0;
        end else if (reg_s[prcfl_pkg::UNIT_R5]) begin
            r5_reached_q <= 1'b1;
        end
    end

    // Short must persist the full window; the latch holds until power cycles
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            short_cnt_q <= 32'h0000_0000;
            cls_latched_q <= 1'b0;
        end else if (!pwr_s) begin
            short_cnt_q <= 32'h0000_0000;
            cls_latched_q <= 1'b0;
        end else if (!sen_s.cls_short) begin
            short_cnt_q <= 32'h0000_0000;
        end else if (short_cnt_q >= 32'(SHORT_CYCLES - 1)) begin
            cls_latched_q <= 1'b1;
        end else begin
            short_cnt_q <= short_cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rail_1p2_en <= 1'b0;
            rail_1p8_en <= 1'b0;
            rail_3p3_en <= 1'b0;
            rail_5p0_en <= 1'b0;
            adjustable_buck_en <= 1'b0;
            boost_converter_en <= 1'b0;
            current_limited_switch_en <= 1'b0;
            current_sense_amp_en <= 1'b0;
            open_drain_comparator_en <= 1'b0;
            sense_gain_40 <= 1'b0;
        end else begin
            rail_1p2_en <= pwr_s;
            rail_1p8_en <= pwr_s;
            rail_3p3_en <= pwr_s;
            // Before regulation the register cannot hold the rail off
            rail_5p0_en <= pwr_s && keep[prcfl_pkg::BLK_R5] &&
                           (!r5_reached_q || enable_q[prcfl_pkg::BLK_R5]);
            adjustable_buck_en <= enable_q[prcfl_pkg::BLK_ADJ] && keep[prcfl_pkg::BLK_ADJ];
            boost_converter_en <= enable_q[prcfl_pkg::BLK_BST] && keep[prcfl_pkg::BLK_BST];
            current_limited_switch_en <= enable_q[prcfl_pkg::BLK_CLS] && keep[prcfl_pkg::BLK_CLS] &&
                                         !cls_latched_q;
            current_sense_amp_en <= enable_q[prcfl_pkg::BLK_CSA] && keep[prcfl_pkg::BLK_CSA];
            open_drain_comparator_en <= enable_q[prcfl_pkg::BLK_CMP] && keep[prcfl_pkg::BLK_CMP];
            sense_gain_40 <= mode_q[prcfl_pkg::MODE_GAIN];
        end
    end

    // ****************************************
    // GPIO and PWM
    // ****************************************
    logic [7:0] pwm_cnt_q;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pwm_cnt_q <= 8'h00;
        end else begin
            pwm_cnt_q <= pwm_cnt_q + 8'h01;
        end
    end

    genvar g;
    generate
        for (g = 0; g < GPIO_W; g++) begin : g_pin
            logic [1:0] pm;
            logic drive_low;
            logic pwm_hi;
            assign pm = gpio_mode_q[2*g +: 2];
            // Pin selects its duty bank
            assign pwm_hi = pwm_cnt_q < (pwm_bank_q[g] ? duty1_q : duty0_q);
            assign drive_low = pwm_en_q[g] ? pwm_hi : gpio_dout_q[g];
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    gpio_out[g] <= 1'b0;
                    gpio_oe[g] <= 1'b0;
                    gpio_pullup_en[g] <= 1'b0;
                end else begin
                    gpio_out[g] <= 1'b0;
                    case (pm)
                        prcfl_pkg::GM_IN_PU: begin
                            gpio_oe[g] <= 1'b0;
                            gpio_pullup_en[g] <= 1'b1;
                        end
                        prcfl_pkg::GM_OD_PU: begin
                            gpio_oe[g] <= drive_low;
                            gpio_pullup_en[g] <= !drive_low;
                        end
                        prcfl_pkg::GM_OD_Z: begin
                            gpio_oe[g] <= drive_low;
                            gpio_pullup_en[g] <= 1'b0;
                        end
                        default: begin
                            gpio_oe[g] <= 1'b0;
                            gpio_pullup_en[g] <= 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

endmodule // prcfl_top

// >>> verilog/prcfl_pkg.sv
package prcfl_pkg;

    // ****************************************
    // Register map (byte addresses on APB)
    // ****************************************
    localparam logic [7:0] ADDR_ENABLE = 8'h00;
    localparam logic [7:0] ADDR_MODE = 8'h04;
    localparam logic [7:0] ADDR_SHUTDOWN = 8'h08;
    localparam logic [7:0] ADDR_SYS_FAULT = 8'h0C;
    localparam logic [7:0] ADDR_OVERLOAD = 8'h10;
    localparam logic [7:0] ADDR_VOK_FAULT = 8'h14;
    localparam logic [7:0] ADDR_GPIO_MODE_LO = 8'h18;
    localparam logic [7:0] ADDR_GPIO_MODE_HI = 8'h1C;
    localparam logic [7:0] ADDR_GPIO_OUT = 8'h20;
    localparam logic [7:0] ADDR_GPIO_IN = 8'h24;
    localparam logic [7:0] ADDR_PWM_EN = 8'h28;
    localparam logic [7:0] ADDR_PWM_BANK = 8'h2C;
    localparam logic [7:0] ADDR_PWM_DUTY0 = 8'h30;
    localparam logic [7:0] ADDR_PWM_DUTY1 = 8'h34;

    // ****************************************
    // Block bit positions (enable and shutdown mask)
    // ****************************************
    localparam int BLK_CSA = 0;
    localparam int BLK_CMP = 1;
    localparam int BLK_BST = 2;
    localparam int BLK_ADJ = 3;
    localparam int BLK_R5 = 4;
    localparam int BLK_CLS = 5;
    localparam int NUM_BLK = 6;

    // Mode register fields
    localparam int MODE_GAIN = 0;
    localparam int MODE_OCDET = 1;

    // System fault bits
    localparam int SF_BST = 0;
    localparam int SF_VOK = 1;
    localparam int SF_OL = 2;
    localparam int SF_OT = 3;
    localparam int SF_INPUT_OVERCURRENT_FLAG = 4;
    localparam int SF_OVIN = 5;
    localparam int NUM_SF = 6;

    // Unit index for overload and voltage-ok: 1p2,1p8,3p3,5p0,adj,bst,cls
    localparam int NUM_UNIT = 7;
    localparam int UNIT_R5 = 3;
    localparam int UNIT_CLS = 6;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_SHUTDOWN = 8'h00;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    // GPIO pin modes, two bits per pin
    localparam logic [1:0] GM_IN_PU = 2'h0;
    localparam logic [1:0] GM_OD_PU = 2'h1;
    localparam logic [1:0] GM_OD_Z = 2'h2;
    localparam logic [1:0] GM_HIZ = 2'h3;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 25_000_000;
    localparam int SHORT_MS = 250;
    localparam int SHORT_CYC = (CLK_HZ / 1000) * SHORT_MS;

    // Analog fault sense bundle
    typedef struct packed {
        logic [NUM_UNIT-1:0] overload;
        logic [NUM_UNIT-1:0] vok_low;
        logic [NUM_UNIT-1:0] soft_start_fail;
        logic bst_fault;
        logic over_temp;
        logic in_overcurrent;
        logic in_overvolt;
        logic cls_short;
    } prcfl_sense_s;

endpackage : prcfl_pkg

// >>> verilog/prcfl_sync.sv
`timescale 1ns/1ps
module prcfl_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // prcfl_sync

// >>> verilog/prcfl_sticky.sv
`timescale 1ns/1ps
module prcfl_sticky #(
    parameter int W = 8
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [W-1:0] cond,
    input wire logic rd,
    output logic [W-1:0] flags
);
    logic [W-1:0] seen_q;

    // Bit sets on fault; the first read after the fault is gone arms it, the next such read clears it
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            flags <= '0;
            seen_q <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (cond[i]) begin
                    flags[i] <= 1'b1;
                    seen_q[i] <= 1'b0;
                end else if (rd && flags[i]) begin
                    if (seen_q[i]) begin
                        flags[i] <= 1'b0;
                        seen_q[i] <= 1'b0;
                    end else begin
                        seen_q[i] <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // prcfl_sticky

// >>> tb/prcfl_host.sv
`timescale 1ns/1ps
// ********
// Register host model on the APB side
// ********
module prcfl_host (
    input wire logic mclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'hFF;
        pwdata = 32'hFFFF_FFFF;
    end

    // One byte-wide register transfer: address phase, then data held until pready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        q = prdata;
        e = pslverr;
        // Released address and data lines show the inverse so the slave cannot lean on stale values
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // prcfl_host

// >>> tb/prcfl_asserts.sv
`timescale 1ns/1ps
module prcfl_top_chk (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic power_on_input,
    input wire prcfl_pkg::prcfl_sense_s sense,
    input wire logic rail_1p2_en,
    input wire logic rail_1p8_en,
    input wire logic rail_3p3_en,
    input wire logic rail_5p0_en,
    input wire logic sense_gain_40,
    input wire logic fault_output_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // Synchronisers hold reset values for a few edges, so pin checks wait here
    logic [2:0] up_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            up_q <= 3'h0;
        end else if (up_q != 3'h7) begin
            up_q <= up_q + 3'h1;
        end
    end

    // ********
    // Assertions
    // ********
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("no access answer after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    unmapped_err_a: assert property (psel && !penable && (paddr > 8'h34 || paddr[1:0] != 2'h0)
        |=> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
    byte_data_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read data not zero");
    gain_write_a: assert property (psel && penable && pready && pwrite && paddr == prcfl_pkg::ADDR_MODE
        |=> ##1 sense_gain_40 == $past(pwdata[0], 2)) else $error("gain select not following mode write");
    low_rails_a: assert property (up_q == 3'h7 |-> rail_1p2_en == $past(power_on_input, 3)
        && rail_1p8_en == rail_1p2_en && rail_3p3_en == rail_1p2_en) else $error("low rails not following power");
    five_on_a: assert property (up_q == 3'h7 && $past(power_on_input, 3) && !$past(power_on_input, 4)
        |-> rail_5p0_en) else $error("5V rail not on with power");
    fault_pin_a: assert property (up_q == 3'h7 && $past(sense.over_temp || sense.in_overvolt || sense.bst_fault, 3)
        |-> !fault_output_n) else $error("fault pin not low on fault");
endmodule // prcfl_top_chk

bind prcfl_top prcfl_top_chk i_chk (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .power_on_input, .sense, .rail_1p2_en, .rail_1p8_en, .rail_3p3_en, .rail_5p0_en, .sense_gain_40,
    .fault_output_n);

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    // ********
    // Stimulus and design
    // ********
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic power_on_input = 1'b0;
    logic emergency_shutdown_n = 1'b1;
    prcfl_pkg::prcfl_sense_s sense = '0;
    logic [6:0] in_regulation = 7'h00;
    logic [7:0] gpio_in = 8'h00;
    logic psel, penable, pwrite, pready, pslverr, er, rail_1p2_en, rail_1p8_en, rail_3p3_en, rail_5p0_en;
    logic adjustable_buck_en, boost_converter_en, current_limited_switch_en, current_sense_amp_en;
    logic open_drain_comparator_en, sense_gain_40, fault_output_n;
    logic [7:0] paddr, gpio_out, gpio_oe, gpio_pullup_en;
    logic [31:0] pwdata, prdata, rv;
    logic [7:0] regs0[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    logic [5:0] masks[2] = '{6'h05, 6'h3A};
    logic [7:0] banks[2] = '{8'hC0, 8'h30};
    int num_errors = 0;
    int checks_done = 0;
    int n0, n1;
    wire [5:0] blk = {current_limited_switch_en, rail_5p0_en, adjustable_buck_en, boost_converter_en,
        open_drain_comparator_en, current_sense_amp_en};
    wire [3:0] rails = {rail_1p2_en, rail_1p8_en, rail_3p3_en, rail_5p0_en};

    always #20 mclk = ~mclk;

    // Short fault timer keeps the latch-off case to a few dozen cycles
    prcfl_top #(.SHORT_CYCLES(20)) i_dut (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .power_on_input, .emergency_shutdown_n, .sense, .in_regulation, .rail_1p2_en,
        .rail_1p8_en, .rail_3p3_en, .rail_5p0_en, .adjustable_buck_en, .boost_converter_en,
        .current_limited_switch_en, .current_sense_amp_en, .open_drain_comparator_en, .sense_gain_40,
        .fault_output_n, .gpio_in, .gpio_out, .gpio_oe, .gpio_pullup_en);
    prcfl_host i_host (.mclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.xfer(1'b1, a, {24'h00_0000, d}, rv, er);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        i_host.xfer(1'b0, a, 32'h0000_0000, rv, er);
        chk($sformatf("reg %h", a), e, rv[7:0]);
    endtask
    // Six reads of the system register and two of each unit register leave every cleared fault at zero
    task automatic fcase(input prcfl_pkg::prcfl_sense_s s, input logic [7:0] a, input logic [7:0] e);
        sense <= s;
        wt(4);
        chk("fault_n", 8'h00, {7'h00, fault_output_n});
        rchk(a, e);
        sense <= '0;
        wt(4);
        repeat (6) i_host.xfer(1'b0, 8'h0C, 32'h0000_0000, rv, er);
        repeat (2) i_host.xfer(1'b0, 8'h10, 32'h0000_0000, rv, er);
        repeat (2) i_host.xfer(1'b0, 8'h14, 32'h0000_0000, rv, er);
    endtask

    initial begin
        #1_200_000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        prcfl_pkg::prcfl_sense_s s;
        wt(2);
        nrst <= 1'b1;
        foreach (regs0[i]) rchk(regs0[i], 8'h00);
        wr(8'h01, 8'h3F);
        chk("slverr", 8'h01, {7'h00, er});
        rchk(prcfl_pkg::ADDR_ENABLE, 8'h00);
        wr(prcfl_pkg::ADDR_SYS_FAULT, 8'hFF);
        rchk(prcfl_pkg::ADDR_SYS_FAULT, 8'h00);
        power_on_input <= 1'b1;
        wt(4);
        chk("rails", 8'h0F, {4'h0, rails});
        wr(prcfl_pkg::ADDR_ENABLE, 8'h00);
        wt(3);
        chk("rails", 8'h0F, {4'h0, rails});
        in_regulation <= 7'h08;
        wt(4);
        wr(prcfl_pkg::ADDR_ENABLE, 8'h00);
        wt(3);
        chk("rails", 8'h0E, {4'h0, rails});
        for (int i = 0; i < 6; i++) begin
            wr(prcfl_pkg::ADDR_ENABLE, 8'(1 << i));
            wt(3);
            chk("blocks", 8'(1 << i), {2'h0, blk});
        end
        foreach (masks[k]) begin
            wr(prcfl_pkg::ADDR_ENABLE, 8'h3F);
            wr(prcfl_pkg::ADDR_SHUTDOWN, {2'h0, masks[k]});
            emergency_shutdown_n <= 1'b0;
            wt(4);
            chk("masked", {2'h0, masks[k]}, {2'h0, blk});
            emergency_shutdown_n <= 1'b1;
            wt(4);
            chk("unmasked", 8'h3F, {2'h0, blk});
        end
        for (int g = 1; g >= 0; g--) begin
            wr(prcfl_pkg::ADDR_MODE, 8'(g));
            wt(2);
            chk("gain", 8'(g), {7'h00, sense_gain_40});
        end
        sense.in_overcurrent <= 1'b1;
        wt(5);
        chk("fault_n", 8'h01, {7'h00, fault_output_n});
        rchk(prcfl_pkg::ADDR_SYS_FAULT, 8'h00);
        wr(prcfl_pkg::ADDR_MODE, 8'h02);
        wt(4);
        chk("fault_n", 8'h00, {7'h00, fault_output_n});
        rchk(prcfl_pkg::ADDR_SYS_FAULT, 8'h10);
        rchk(prcfl_pkg::ADDR_SYS_FAULT, 8'h10);
        sense <= '0;
        wt(4);
        chk("fault_n", 8'h01, {7'h00, fault_output_n});
        i_host.xfer(1'b0, prcfl_pkg::ADDR_SYS_FAULT, 32'h0000_0000, rv, er);
        // Clearing read still returns the latched bit; the clear shows on the next read
        rchk(prcfl_pkg::ADDR_SYS_FAULT, 8'h10);
        rchk(prcfl_pkg::ADDR_SYS_FAULT, 8'h00);
        s = '0;
        s.overload = 7'h40;
        fcase(s, prcfl_pkg::ADDR_OVERLOAD, 8'h40);
        s = '0;
        s.overload = 7'h01;
        fcase(s, prcfl_pkg::ADDR_SYS_FAULT, 8'h04);
        s = '0;
        s.vok_low = 7'h08;
        fcase(s, prcfl_pkg::ADDR_VOK_FAULT, 8'h08);
        s = '0;
        s.soft_start_fail = 7'h10;
        fcase(s, prcfl_pkg::ADDR_VOK_FAULT, 8'h10);
        fcase(s, prcfl_pkg::ADDR_SYS_FAULT, 8'h02);
        s = '0;
        s.bst_fault = 1'b1;
        fcase(s, prcfl_pkg::ADDR_SYS_FAULT, 8'h01);
        s = '0;
        s.over_temp = 1'b1;
        fcase(s, prcfl_pkg::ADDR_SYS_FAULT, 8'h08);
        s = '0;
        s.in_overvolt = 1'b1;
        fcase(s, prcfl_pkg::ADDR_SYS_FAULT, 8'h20);
        wr(prcfl_pkg::ADDR_ENABLE, 8'h30);
        s = '0;
        s.cls_short = 1'b1;
        sense <= s;
        wt(10);
        sense <= '0;
        wt(4);
        chk("switch", 8'h01, {7'h00, current_limited_switch_en});
        sense <= s;
        wt(30);
        sense <= '0;
        wt(4);
        chk("switch", 8'h00, {7'h00, current_limited_switch_en});
        wr(prcfl_pkg::ADDR_GPIO_MODE_LO, 8'hE4);
        wr(prcfl_pkg::ADDR_GPIO_OUT, 8'h0F);
        wt(2);
        chk("oe", 8'h06, {4'h0, gpio_oe[3:0]});
        chk("pullup", 8'h01, {5'h00, gpio_pullup_en[3:2], gpio_pullup_en[0]});
        wr(prcfl_pkg::ADDR_GPIO_OUT, 8'h00);
        wt(2);
        chk("oe", 8'h00, {4'h0, gpio_oe[3:0]});
        chk("pullup", 8'h03, {4'h0, gpio_pullup_en[3:0]});
        chk("gpio_out", 8'h00, gpio_out);
        gpio_in <= 8'hA5;
        wt(4);
        rchk(prcfl_pkg::ADDR_GPIO_IN, 8'hA5);
        wr(prcfl_pkg::ADDR_GPIO_MODE_HI, 8'hAA);
        wr(prcfl_pkg::ADDR_PWM_EN, 8'hF0);
        wr(prcfl_pkg::ADDR_PWM_DUTY0, 8'h40);
        wr(prcfl_pkg::ADDR_PWM_DUTY1, 8'hC0);
        foreach (banks[k]) begin
            wr(prcfl_pkg::ADDR_PWM_BANK, banks[k]);
            wt(2);
            n0 = 0;
            n1 = 0;
            repeat (256) begin
                @(posedge mclk);
                n0 += int'(gpio_oe[4]);
                n1 += int'(gpio_oe[7]);
            end
            chk("pwm pin4", banks[k][4] ? 8'hC0 : 8'h40, 8'(n0));
            chk("pwm pin7", banks[k][7] ? 8'hC0 : 8'h40, 8'(n1));
        end
        power_on_input <= 1'b0;
        wt(4);
        chk("low rails", 8'h00, {5'h00, rails[3:1]});
        report_and_stop();
    end
endmodule // testbench
